// ==== rtl/srtd_defines.svh ====
// Constants of the sample-rate scheduler and tilt debounce block.
// Assumes a 100 ns system clock; included by its bare name.
`ifndef SRTD_DEFINES_SVH
`define SRTD_DEFINES_SVH
`define SRTD_CLK_PERIOD_NS 100
`define SRTD_T_120_NS      8360000
`define SRTD_T_64_NS       15625000
`define SRTD_T_32_NS       31250000
`define SRTD_T_16_NS       62500000
`define SRTD_T_8_NS        125000000
`define SRTD_T_4_NS        250000000
`define SRTD_T_2_NS        500000000
`define SRTD_T_1_NS        1000000000
`define SRTD_CYC_120 (`SRTD_T_120_NS / `SRTD_CLK_PERIOD_NS)
`define SRTD_CYC_64  (`SRTD_T_64_NS / `SRTD_CLK_PERIOD_NS)
`define SRTD_CYC_32  (`SRTD_T_32_NS / `SRTD_CLK_PERIOD_NS)
`define SRTD_CYC_16  (`SRTD_T_16_NS / `SRTD_CLK_PERIOD_NS)
`define SRTD_CYC_8   (`SRTD_T_8_NS / `SRTD_CLK_PERIOD_NS)
`define SRTD_CYC_4   (`SRTD_T_4_NS / `SRTD_CLK_PERIOD_NS)
`define SRTD_CYC_2   (`SRTD_T_2_NS / `SRTD_CLK_PERIOD_NS)
`define SRTD_CYC_1   (`SRTD_T_1_NS / `SRTD_CLK_PERIOD_NS)
`define SRTD_ADDR_X        8'h00
`define SRTD_ADDR_Y        8'h01
`define SRTD_ADDR_Z        8'h02
`define SRTD_ADDR_TILT     8'h03
`define SRTD_ADDR_SR       8'h08
`define SRTD_SR_RESET      8'h00
`define SRTD_SR_ACT_LSB    0
`define SRTD_SR_WAKE_LSB   3
`define SRTD_SR_ORIENTATION_DEBOUNCE_COUNT_LSB   5
`define SRTD_TILT_POLA_LSB 2
`define SRTD_BURST_LOG2    5
`define SRTD_MEAS_W        6
`endif

// ==== rtl/srtd_pkg.sv ====
// Types shared by the sample-rate scheduler and tilt debounce block.
// Rate field codes follow the sample rate configuration register; orientation codes feed the tilt register.
package srtd_pkg;
    typedef enum logic [2:0] {
        active_rate_120 = 3'h0, active_rate_64 = 3'h1, active_rate_32 = 3'h2,
        active_rate_16 = 3'h3, active_rate_8 = 3'h4, active_rate_4 = 3'h5,
        active_rate_2 = 3'h6, active_rate_1 = 3'h7
    } srtd_active_rate_type;
    typedef enum logic [1:0] {
        wake_rate_32 = 2'h0, wake_rate_16 = 2'h1, wake_rate_8 = 2'h2, wake_rate_1 = 2'h3
    } srtd_wake_rate_type;
    typedef enum logic [2:0] {
        orient_unknown = 3'h0, orient_land_left = 3'h1, orient_land_right = 3'h2,
        orient_port_down = 3'h5, orient_port_up = 3'h6
    } srtd_orient_type;
endpackage

// ==== rtl/srtd_result_if.sv ====
// Averaged axis result carried from the burst averager to the core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface srtd_result_if #(parameter int W = 6) ();
    logic              valid;
    logic signed [W-1:0] x;
    logic signed [W-1:0] y;
    logic signed [W-1:0] z;
    modport src (output valid, output x, output y, output z);
    modport snk (input valid, input x, input y, input z);
endinterface
`default_nettype wire

// ==== rtl/srtd_rate_timer.sv ====
// Result period scheduler: one tick per selected measurement period.
// Assumes the rate fields are held in a register of the caller.
`timescale 1ns/1ps
`default_nettype none
`include "srtd_defines.svh"
module srtd_rate_timer #(
    parameter logic [23:0] CYC_120 = 24'(`SRTD_CYC_120),
    parameter logic [23:0] CYC_64  = 24'(`SRTD_CYC_64),
    parameter logic [23:0] CYC_32  = 24'(`SRTD_CYC_32),
    parameter logic [23:0] CYC_16  = 24'(`SRTD_CYC_16),
    parameter logic [23:0] CYC_8   = 24'(`SRTD_CYC_8),
    parameter logic [23:0] CYC_4   = 24'(`SRTD_CYC_4),
    parameter logic [23:0] CYC_2   = 24'(`SRTD_CYC_2),
    parameter logic [23:0] CYC_1   = 24'(`SRTD_CYC_1)
) (
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    input  wire logic                           wake_mode,
    input  wire srtd_pkg::srtd_active_rate_type act_sel,
    input  wire srtd_pkg::srtd_wake_rate_type   wake_sel,
    output logic                                tick
);
    import srtd_pkg::*;
    typedef struct packed {
        logic [23:0] cnt;
        logic        tick;
    } srtd_timer_st_type;
    srtd_timer_st_type st;
    srtd_timer_st_type next_st;
    logic [23:0]       period;

    always_comb begin
        period = CYC_1;
        if (wake_mode) begin
            unique case (wake_sel)
                wake_rate_32: period = CYC_32;
                wake_rate_16: period = CYC_16;
                wake_rate_8:  period = CYC_8;
                wake_rate_1:  period = CYC_1;
            endcase
        end else begin
            unique case (act_sel)
                active_rate_120: period = CYC_120;
                active_rate_64:  period = CYC_64;
                active_rate_32:  period = CYC_32;
                active_rate_16:  period = CYC_16;
                active_rate_8:   period = CYC_8;
                active_rate_4:   period = CYC_4;
                active_rate_2:   period = CYC_2;
                active_rate_1:   period = CYC_1;
            endcase
        end
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt >= period - 24'h1) begin
            next_st.cnt = 24'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 24'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    // Cycles between ticks and whether the period held steady
    logic [23:0] gap;
    logic [23:0] prev_period;
    logic        steady;
    logic        seen;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 24'h0;
            prev_period <= 24'h0;
            steady <= 1'b0;
            seen <= 1'b0;
        end else begin
            prev_period <= period;
            gap <= tick ? 24'h1 : gap + 24'h1;
            if (tick) begin
                seen <= 1'b1;
                steady <= 1'b1;
            end else if (period != prev_period) begin
                steady <= 1'b0;
            end
        end
    end

    property p_tick_period;
        @(posedge ref_clk) disable iff (!rst_n)
        tick && seen && steady && (period == prev_period) |-> gap == period;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick spacing off period");

    property p_tick_pulse;
        @(posedge ref_clk) disable iff (!rst_n)
        tick && (period > 24'h1) |=> !tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick wider than one cycle");
endmodule
`default_nettype wire

// ==== rtl/srtd_burst_avg.sv ====
// Burst averager: sums a burst of axis measurements and divides by its length.
// Assumes the front end offers one measurement per cycle at most.
`timescale 1ns/1ps
`default_nettype none
`include "srtd_defines.svh"
module srtd_burst_avg #(
    parameter int MEAS_W     = `SRTD_MEAS_W,
    parameter int BURST_LOG2 = `SRTD_BURST_LOG2
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     start,
    input  wire logic                     meas_valid,
    input  wire logic signed [MEAS_W-1:0] meas_x,
    input  wire logic signed [MEAS_W-1:0] meas_y,
    input  wire logic signed [MEAS_W-1:0] meas_z,
    output logic                          meas_ready,
    srtd_result_if.src                    res
);
    import srtd_pkg::*;
    localparam int SW = MEAS_W + BURST_LOG2;
    localparam logic [BURST_LOG2-1:0] LAST = '1;
    typedef enum logic {avg_idle, avg_collect} srtd_avg_state_type;
    typedef struct packed {
        srtd_avg_state_type      state;
        logic [BURST_LOG2-1:0]   cnt;
        logic signed [SW-1:0]     sx;
        logic signed [SW-1:0]     sy;
        logic signed [SW-1:0]     sz;
        logic                    valid;
        logic signed [MEAS_W-1:0] ax;
        logic signed [MEAS_W-1:0] ay;
        logic signed [MEAS_W-1:0] az;
    } srtd_avg_st_type;
    srtd_avg_st_type      st;
    srtd_avg_st_type      next_st;
    logic signed [SW-1:0] sum_x;
    logic signed [SW-1:0] sum_y;
    logic signed [SW-1:0] sum_z;

    assign sum_x = st.sx + {{BURST_LOG2{meas_x[MEAS_W-1]}}, meas_x};
    assign sum_y = st.sy + {{BURST_LOG2{meas_y[MEAS_W-1]}}, meas_y};
    assign sum_z = st.sz + {{BURST_LOG2{meas_z[MEAS_W-1]}}, meas_z};

    always_comb begin
        next_st = st;
        next_st.valid = 1'b0;
        unique case (st.state)
            avg_idle: begin
                if (start) begin
                    next_st.state = avg_collect;
                    next_st.cnt = '0;
                    next_st.sx = '0;
                    next_st.sy = '0;
                    next_st.sz = '0;
                end
            end
            avg_collect: begin
                if (meas_valid) begin
                    next_st.sx = sum_x;
                    next_st.sy = sum_y;
                    next_st.sz = sum_z;
                    next_st.cnt = BURST_LOG2'(st.cnt + 1);
                    if (st.cnt == LAST) begin
                        next_st.state = avg_idle;
                        next_st.valid = 1'b1;
                        next_st.ax = sum_x[SW-1:BURST_LOG2];
                        next_st.ay = sum_y[SW-1:BURST_LOG2];
                        next_st.az = sum_z[SW-1:BURST_LOG2];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign meas_ready = (st.state == avg_collect);
    assign res.valid = st.valid;
    assign res.x = st.ax;
    assign res.y = st.ay;
    assign res.z = st.az;

    // Measurements taken since the burst began
    logic [BURST_LOG2:0] taken;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            taken <= '0;
        end else if (st.state == avg_idle) begin
            taken <= '0;
        end else if (meas_valid) begin
            taken <= taken + 1'b1;
        end
    end

    property p_burst_len;
        @(posedge ref_clk) disable iff (!rst_n)
        res.valid |-> taken == (BURST_LOG2 + 1)'(1 << BURST_LOG2);
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst length wrong");

    property p_valid_pulse;
        @(posedge ref_clk) disable iff (!rst_n)
        res.valid |=> !res.valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("result valid too long");
endmodule
`default_nettype wire

// ==== rtl/srtd_sample_rate_tilt_debounce.sv ====
// Sample-rate scheduler, burst averaging and orientation debounce core.
// Assumes a register port driven by a serial slave and a measuring front end.
`timescale 1ns/1ps
`default_nettype none
`include "srtd_defines.svh"
module srtd_sample_rate_tilt_debounce #(
    parameter int          MEAS_W  = `SRTD_MEAS_W,
    parameter logic [23:0] CYC_120 = 24'(`SRTD_CYC_120),
    parameter logic [23:0] CYC_64  = 24'(`SRTD_CYC_64),
    parameter logic [23:0] CYC_32  = 24'(`SRTD_CYC_32),
    parameter logic [23:0] CYC_16  = 24'(`SRTD_CYC_16),
    parameter logic [23:0] CYC_8   = 24'(`SRTD_CYC_8),
    parameter logic [23:0] CYC_4   = 24'(`SRTD_CYC_4),
    parameter logic [23:0] CYC_2   = 24'(`SRTD_CYC_2),
    parameter logic [23:0] CYC_1   = 24'(`SRTD_CYC_1)
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     auto_wake_mode,
    input  wire logic                     meas_valid,
    input  wire logic signed [MEAS_W-1:0] meas_x,
    input  wire logic signed [MEAS_W-1:0] meas_y,
    input  wire logic signed [MEAS_W-1:0] meas_z,
    output logic                          meas_ready,
    input  wire logic [7:0]               reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    output logic                          reg_rvalid,
    output srtd_pkg::srtd_orient_type     orientation
);
    import srtd_pkg::*;
    typedef struct packed {
        logic [7:0]               sample_rate_config;
        logic signed [MEAS_W-1:0] x_axis_result;
        logic signed [MEAS_W-1:0] y_axis_result;
        logic signed [MEAS_W-1:0] z_axis_result;
        srtd_orient_type          pola;
        srtd_orient_type          cand;
        logic                     cand_valid;
        logic [2:0]               match_cnt;
        logic [7:0]               rdata;
        logic                     rvalid;
    } srtd_core_st_type;

    localparam srtd_core_st_type RESET_ST = '{
        sample_rate_config: `SRTD_SR_RESET,
        x_axis_result: '0,
        y_axis_result: '0,
        z_axis_result: '0,
        pola: orient_unknown,
        cand: orient_unknown,
        cand_valid: 1'b0,
        match_cnt: 3'h0,
        rdata: 8'h00,
        rvalid: 1'b0
    };

    srtd_core_st_type     st;
    srtd_core_st_type     next_st;
    srtd_active_rate_type active_rate_select;
    srtd_wake_rate_type   wake_rate_select;
    logic [2:0]           orientation_debounce_count;
    logic                 period_tick;
    srtd_orient_type      reading;
    logic                 cnt_hit;
    logic                 mismatch;
    logic [7:0]           tilt_value;

    srtd_result_if #(.W(MEAS_W)) avg_res ();

    assign active_rate_select = srtd_active_rate_type'(st.sample_rate_config[`SRTD_SR_ACT_LSB +: 3]);
    assign wake_rate_select = srtd_wake_rate_type'(st.sample_rate_config[`SRTD_SR_WAKE_LSB +: 2]);
    assign orientation_debounce_count = st.sample_rate_config[`SRTD_SR_ORIENTATION_DEBOUNCE_COUNT_LSB +: 3];

    srtd_rate_timer #(
        .CYC_120 (CYC_120),
        .CYC_64  (CYC_64),
        .CYC_32  (CYC_32),
        .CYC_16  (CYC_16),
        .CYC_8   (CYC_8),
        .CYC_4   (CYC_4),
        .CYC_2   (CYC_2),
        .CYC_1   (CYC_1)
    ) srtd_rate_timer_i (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .wake_mode (auto_wake_mode),
        .act_sel   (active_rate_select),
        .wake_sel  (wake_rate_select),
        .tick      (period_tick)
    );

    srtd_burst_avg #(
        .MEAS_W     (MEAS_W),
        .BURST_LOG2 (`SRTD_BURST_LOG2)
    ) srtd_burst_avg_i (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .start      (period_tick),
        .meas_valid (meas_valid),
        .meas_x     (meas_x),
        .meas_y     (meas_y),
        .meas_z     (meas_z),
        .meas_ready (meas_ready),
        .res        (avg_res)
    );

    // Portrait when Y dominates, landscape when X dominates
    function automatic srtd_orient_type classify(input logic signed [MEAS_W-1:0] ax,
                                                 input logic signed [MEAS_W-1:0] ay);
        logic [MEAS_W:0] mag_x;
        logic [MEAS_W:0] mag_y;
        mag_x = ax[MEAS_W-1] ? (MEAS_W + 1)'(-ax) : (MEAS_W + 1)'(ax);
        mag_y = ay[MEAS_W-1] ? (MEAS_W + 1)'(-ay) : (MEAS_W + 1)'(ay);
        if (mag_x > mag_y) begin
            classify = ax[MEAS_W-1] ? orient_land_right : orient_land_left;
        end else if (mag_y > mag_x) begin
            classify = ay[MEAS_W-1] ? orient_port_down : orient_port_up;
        end else begin
            classify = orient_unknown;
        end
    endfunction

    assign reading = classify(avg_res.x, avg_res.y);
    assign cnt_hit = ({1'b0, st.match_cnt} + 4'h1) == {1'b0, orientation_debounce_count};
    assign mismatch = !st.cand_valid || (reading != st.cand);
    assign tilt_value = 8'({st.pola, 2'b00});

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        if (reg_wr && (reg_addr == `SRTD_ADDR_SR)) begin
            next_st.sample_rate_config = reg_wdata;
        end
        if (reg_rd) begin
            next_st.rvalid = 1'b1;
            case (reg_addr)
                `SRTD_ADDR_X:    next_st.rdata = 8'(unsigned'(st.x_axis_result));
                `SRTD_ADDR_Y:    next_st.rdata = 8'(unsigned'(st.y_axis_result));
                `SRTD_ADDR_Z:    next_st.rdata = 8'(unsigned'(st.z_axis_result));
                `SRTD_ADDR_TILT: next_st.rdata = tilt_value;
                `SRTD_ADDR_SR:   next_st.rdata = st.sample_rate_config;
                default:         next_st.rdata = 8'h00;
            endcase
        end
        if (avg_res.valid) begin
            next_st.x_axis_result = avg_res.x;
            next_st.y_axis_result = avg_res.y;
            next_st.z_axis_result = avg_res.z;
            if (orientation_debounce_count == 3'h0) begin
                next_st.pola = reading;
                next_st.cand = reading;
                next_st.cand_valid = 1'b1;
                next_st.match_cnt = 3'h0;
            end else if (mismatch) begin
                next_st.cand = reading;
                next_st.cand_valid = 1'b1;
                next_st.match_cnt = 3'h0;
            end else begin
                if (st.match_cnt < orientation_debounce_count) begin
                    next_st.match_cnt = st.match_cnt + 3'h1;
                end
                if (cnt_hit) begin
                    next_st.pola = reading;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign orientation = st.pola;

    property p_axis_update;
        @(posedge ref_clk) disable iff (!rst_n)
        avg_res.valid |=> (st.x_axis_result == $past(avg_res.x))
                       && (st.y_axis_result == $past(avg_res.y))
                       && (st.z_axis_result == $past(avg_res.z));
    endproperty
    a_axis_update: assert property (p_axis_update) else $error("axis result not refreshed");

    property p_filter_off;
        @(posedge ref_clk) disable iff (!rst_n)
        avg_res.valid && (orientation_debounce_count == 3'h0) |=> orientation == $past(reading);
    endproperty
    a_filter_off: assert property (p_filter_off) else $error("undebounced update missing");

    property p_restart;
        @(posedge ref_clk) disable iff (!rst_n)
        avg_res.valid && (orientation_debounce_count != 3'h0) && mismatch
        |=> $stable(orientation) && (st.match_cnt == 3'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("mismatch did not restart count");

    property p_update_cause;
        @(posedge ref_clk) disable iff (!rst_n)
        !$stable(orientation) |-> $past(avg_res.valid)
                               && ($past(orientation_debounce_count) == 3'h0 || $past(cnt_hit));
    endproperty
    a_update_cause: assert property (p_update_cause) else $error("orientation changed early");

    property p_tilt_read;
        @(posedge ref_clk) disable iff (!rst_n)
        reg_rd && (reg_addr == `SRTD_ADDR_TILT) && !avg_res.valid
        |=> reg_rvalid && (reg_rdata == tilt_value);
    endproperty
    a_tilt_read: assert property (p_tilt_read) else $error("tilt register read wrong");

    property p_cfg_write;
        @(posedge ref_clk) disable iff (!rst_n)
        reg_wr && (reg_addr == `SRTD_ADDR_SR) |=> st.sample_rate_config == $past(reg_wdata);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("rate config write lost");

    property p_unmapped;
        @(posedge ref_clk) disable iff (!rst_n)
        reg_rd && (reg_addr > `SRTD_ADDR_TILT) && (reg_addr != `SRTD_ADDR_SR)
        |=> reg_rvalid && (reg_rdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_rvalid_cause;
        @(posedge ref_clk) disable iff (!rst_n)
        reg_rvalid |-> $past(reg_rd);
    endproperty
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("read answer without request");

    property p_cov_debounced;
        @(posedge ref_clk) disable iff (!rst_n)
        avg_res.valid && cnt_hit && !mismatch && (orientation_debounce_count == 3'h7);
    endproperty
    c_cov_debounced: cover property (p_cov_debounced);

    property p_cov_wake;
        @(posedge ref_clk) disable iff (!rst_n)
        auto_wake_mode && avg_res.valid;
    endproperty
    c_cov_wake: cover property (p_cov_wake);

    property p_cov_restart;
        @(posedge ref_clk) disable iff (!rst_n)
        avg_res.valid && st.cand_valid && mismatch && (st.match_cnt != 3'h0);
    endproperty
    c_cov_restart: cover property (p_cov_restart);

    property p_cov_filter_off;
        @(posedge ref_clk) disable iff (!rst_n)
        avg_res.valid && (orientation_debounce_count == 3'h0) && (reading != st.pola);
    endproperty
    c_cov_filter_off: cover property (p_cov_filter_off);

    property p_wr_ignored;
        @(posedge ref_clk) disable iff (!rst_n)
        reg_wr && (reg_addr != `SRTD_ADDR_SR) |=> $stable(st.sample_rate_config);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("ignored write took effect");

    property p_axis_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        !avg_res.valid |=> $stable(st.x_axis_result) && $stable(st.y_axis_result)
                        && $stable(st.z_axis_result);
    endproperty
    a_axis_hold: assert property (p_axis_hold) else $error("axis result moved early");

    property p_candidate;
        @(posedge ref_clk) disable iff (!rst_n)
        avg_res.valid |=> st.cand_valid && (st.cand == $past(reading));
    endproperty
    a_candidate: assert property (p_candidate) else $error("candidate not tracking");

    property p_axis_read;
        @(posedge ref_clk) disable iff (!rst_n)
        reg_rd && (reg_addr == `SRTD_ADDR_X) && !avg_res.valid
        |=> reg_rvalid && (reg_rdata == 8'(unsigned'(st.x_axis_result)));
    endproperty
    a_axis_read: assert property (p_axis_read) else $error("x result read wrong");
endmodule
`default_nettype wire

// ==== tb/srtd_front_model.sv ====
// Front-end model: one measurement a cycle, or every other cycle when slow.
// Assumes samples are taken on rising edges.
`timescale 1ns/1ps
`default_nettype none
module srtd_front_model (
    input  wire logic        ref_clk,
    input  wire logic        slow,
    input  wire logic [17:0] val,
    output logic             meas_valid,
    output logic [17:0]      meas
);
    initial begin
        meas_valid = 1'b0;
        meas = 18'h0;
    end
    // Idle cycles carry the inverse so stale data is never taken for good
    always @(posedge ref_clk) begin
        #10;
        meas_valid = slow ? ~meas_valid : 1'b1;
        meas = meas_valid ? val : ~val;
    end
endmodule
`default_nettype wire

// ==== tb/srtd_sample_rate_tilt_debounce_test.sv ====
// Bench of the sample-rate and tilt debounce block.
// Assumes shortened period parameters and the front-end model.
`timescale 1ns/1ps
`default_nettype none
module srtd_sample_rate_tilt_debounce_test;
    import srtd_pkg::*;
    logic            ref_clk = 1'b0, rst_n = 1'b0, wake = 1'b0, slow = 1'b0;
    logic            reg_wr = 1'b0, reg_rd = 1'b0, meas_valid, meas_ready, reg_rvalid;
    logic [17:0]     val = 18'h0, meas;
    logic [7:0]      reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata, d;
    srtd_orient_type orientation;
    int              error_cnt = 0, cmp_count = 0, a, b;
    localparam logic [23:0] c120 = 24'h28, c64 = 24'h32, c32 = 24'h3C, c16 = 24'h46;
    localparam logic [23:0] c8 = 24'h50, c4 = 24'h5A, c2 = 24'h64, c1 = 24'h78;
    logic [23:0]     per[12] = '{c120, c64, c32, c16, c8, c4, c2, c1, c32, c16, c8, c1};
    localparam logic [17:0] lf = 18'h14000, rt = 18'h2C000, up = 18'h00500, dn = 18'h00B00;
    always #50 ref_clk = ~ref_clk;
    srtd_front_model srtd_front_model_i (.ref_clk(ref_clk), .slow(slow), .val(val),
        .meas_valid(meas_valid), .meas(meas));
    srtd_sample_rate_tilt_debounce #(.CYC_120(c120), .CYC_64(c64), .CYC_32(c32),
        .CYC_16(c16), .CYC_8(c8), .CYC_4(c4), .CYC_2(c2), .CYC_1(c1))
        srtd_sample_rate_tilt_debounce_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .auto_wake_mode(wake), .meas_valid(meas_valid), .meas_x(meas[17:12]),
        .meas_y(meas[11:6]), .meas_z(meas[5:0]), .meas_ready(meas_ready),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .orientation(orientation));
    task end_of_test;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Counts edges until meas_ready reaches the level
    task wt(input logic lvl, output int n);
        n = 0;
        while (meas_ready !== lvl) begin
            @(posedge ref_clk);
            #10;
            n++;
            if (n > 300) begin
                error_cnt++;
                $display("Error at %0t: burst wait timed out", $time);
                end_of_test;
            end
        end
    endtask
    task wr(input logic [7:0] adr, input logic [7:0] wd);
        @(posedge ref_clk);
        #10;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, adr, wd};
        @(posedge ref_clk);
        #10;
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] adr);
        @(posedge ref_clk);
        #10;
        {reg_rd, reg_addr} = {1'b1, adr};
        @(posedge ref_clk);
        #10;
        reg_rd = 1'b0;
        check(reg_rvalid, 1'b1);
        d = reg_rdata;
    endtask
    task reading(input logic [17:0] v, input logic [2:0] exp);
        val = v;
        wt(1'b1, a);
        wt(1'b0, a);
        @(posedge ref_clk);
        #10;
        check(orientation, exp);
    endtask
    task rates;
        for (int i = 0; i < 12; i++) begin
            wake = (i > 7);
            wr(8'h08, (i > 7) ? 8'((i - 8) << 3) : 8'(i));
            wt(1'b1, a);
            wt(1'b0, a);
            wt(1'b1, a);
            wt(1'b0, a);
            wt(1'b1, b);
            check(a + b, per[i]);
            check(a, 32'h20);
        end
        wake = 1'b0;
    endtask
    task averages;
        wr(8'h08, 8'h07);
        slow = 1'b1;
        val = {6'h39, 6'h05, 6'h1F};
        repeat (2) wt(1'b1, a);
        wt(1'b0, a);
        wt(1'b1, a);
        wt(1'b0, a);
        repeat (2) @(posedge ref_clk);
        rd(8'h00);
        check(d, 8'h39);
        rd(8'h01);
        check(d, 8'h05);
        rd(8'h02);
        check(d, 8'h1F);
        slow = 1'b0;
    endtask
    task debounce;
        wr(8'h08, 8'h40);
        repeat (2) reading(lf, 3'h2);
        reading(lf, 3'h1);
        rd(8'h03);
        check(d, 8'h04);
        repeat (2) reading(up, 3'h1);
        reading(rt, 3'h1);
        repeat (2) reading(up, 3'h1);
        reading(up, 3'h6);
        wr(8'h08, 8'h00);
        reading(dn, 3'h5);
        reading(lf, 3'h1);
        wr(8'h08, 8'hE0);
        repeat (7) reading(rt, 3'h1);
        reading(rt, 3'h2);
    endtask
    task regs;
        rd(8'h08);
        check(d, 8'h00);
        wr(8'h03, 8'hFF);
        wr(8'h08, 8'hA5);
        rd(8'h08);
        check(d, 8'hA5);
        rd(8'h20);
        check(d, 8'h00);
        rd(8'h03);
        check(d, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        #10;
        rst_n = 1'b1;
        regs;
        rates;
        averages;
        debounce;
        end_of_test;
    end
endmodule
`default_nettype wire
